/* File: rtl/sswc_slave.sv */
// Slave byte write decoder and command actions on the management bus
// Functional notes
// - Byte write: command byte selects, data stored
// - Index 0 is the command register
// - New message byte overwrites old unconditionally
// - Type 1 wakes asleep, else raises SMI
// - Type 1 always sets bus wake status
// - Type 2 sets override flag, powers down
// - Type 3 hard reset, control bits 011
// - Type 3 only in S0, else dropped
// - Type 4 hard reset, control bits 111
// - Type 4 sleep rules on management, graceful entry
// - Type 5 stops messages until resume reset
// - Type 6 reloads the watchdog
// - Type 8 in S0 sets link status
// - Type 8 in sleep acked, status unchanged
// - Link SMI pending until return to S0
// - Programmable 7-bit address, default 44h
// - No packet error code byte handling
// - Slave SMI reported in status bit 16
`default_nettype none

module sswc_slave
  import sswc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output var  logic       sda_out,
  output var  logic       sda_oe_n,
  input  wire logic [6:0] receive_slave_address,
  input  wire logic [2:0] sleep_state,
  input  wire logic       mgmt_powered,
  input  wire logic       graceful_sleep_entry,
  input  wire logic       resume_well_reset_n,
  input  wire logic       bus_wake_status_clear,
  input  wire logic       power_button_override_status_clear,
  input  wire logic       link_slave_interrupt_status_clear,
  input  wire logic       smi_status_bit16_clear,
  output var  logic [7:0] slave_message_byte0,
  output var  logic [7:0] slave_message_byte1,
  output var  logic       wake_request,
  output var  logic       system_mgmt_interrupt_n,
  output var  logic       bus_wake_status,
  output var  logic       power_button_override_status,
  output var  logic       powerdown_request,
  output var  logic       hard_reset_request,
  output var  logic [2:0] reset_control,
  output var  logic       message_reporting_disabled,
  output var  logic       watchdog_reload_command,
  output var  logic       link_slave_interrupt_status,
  output var  logic       smi_status_bit16
);

  // True when the system is in the working state
  function automatic logic in_working(input logic [2:0] s);
    in_working = (s == SSWC_STATE_S0);
  endfunction

  logic        scl_lvl;               // Synchronised clock level
  logic        scl_rise;              // Clock rising, sample data
  logic        scl_fall;              // Clock falling, change data
  logic        sda_lvl;               // Synchronised data level
  logic        sda_rise;              // Data rising
  logic        sda_fall;              // Data falling
  logic        rsm_lvl;               // Synchronised resume-well reset
  sswc_state_t state;                 // Bus engine state
  logic [3:0]  bit_cnt;               // Bits taken in the current byte
  logic [7:0]  shift;                 // Incoming byte
  logic [7:0]  cmd_index;             // Register selected by command byte
  logic        write_strobe;          // One cycle: data byte complete
  logic [7:0]  write_index;           // Index captured with the strobe
  logic [7:0]  write_data;            // Data captured with the strobe
  logic        cmd_exec;              // Command register was written
  logic        link_smi_pending;      // Link SMI waiting for S0
  logic        start_cond;            // Data falls while clock high
  logic        stop_cond;             // Data rises while clock high
  logic        addr_match;            // Address byte is our write address

  // Line synchronisers; both bus lines idle high
  sswc_sync #(.RESET_VAL(1'b1)) u_scl (
    .clk      (clk),
    .resetn   (resetn),
    .async_in (scl_in),
    .level    (scl_lvl),
    .rise     (scl_rise),
    .fall     (scl_fall)
  );

  sswc_sync #(.RESET_VAL(1'b1)) u_sda (
    .clk      (clk),
    .resetn   (resetn),
    .async_in (sda_in),
    .level    (sda_lvl),
    .rise     (sda_rise),
    .fall     (sda_fall)
  );

  // Resume-well reset is a pin from another well, so it is synchronised
  sswc_sync #(.RESET_VAL(1'b0)) u_rsm (
    .clk      (clk),
    .resetn   (resetn),
    .async_in (resume_well_reset_n),
    .level    (rsm_lvl),
    .rise     (),
    .fall     ()
  );

  // Start and stop are data edges while the clock stays high
  assign start_cond = sda_fall & scl_lvl;
  assign stop_cond  = sda_rise & scl_lvl;

  // address match
  // Only the write direction is claimed; reads are not decoded here
  assign addr_match = (shift == {receive_slave_address, 1'b0});

  assign cmd_exec = write_strobe & (write_index == SSWC_IDX_COMMAND);

  // Bus engine: bit shifting, acknowledge and byte sequencing
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state        <= SSWC_IDLE;
      bit_cnt      <= SSWC_BIT_CNT_RESET;
      shift        <= SSWC_BYTE_RESET;
      cmd_index    <= SSWC_BYTE_RESET;
      sda_oe_n     <= 1'b1;
      sda_out      <= 1'b0;
      write_strobe <= 1'b0;
      write_index  <= SSWC_BYTE_RESET;
      write_data   <= SSWC_BYTE_RESET;
    end else begin
      // Open drain: the output level is always low, only the enable moves
      sda_out      <= 1'b0;
      write_strobe <= 1'b0;
      if (start_cond) begin
        // Start or repeated start restarts the address phase
        state    <= SSWC_ADDR;
        bit_cnt  <= SSWC_BIT_CNT_RESET;
        sda_oe_n <= 1'b1;
      end else if (stop_cond) begin
        // Stop ends any transfer and frees the line
        state    <= SSWC_IDLE;
        bit_cnt  <= SSWC_BIT_CNT_RESET;
        sda_oe_n <= 1'b1;
      end else begin
        case (state)
          SSWC_ADDR, SSWC_CMD, SSWC_DATA: begin
            // Sample on the rising clock, most significant bit first
            if (scl_rise && bit_cnt != SSWC_BITS_PER_BYTE) begin
              shift   <= {shift[6:0], sda_lvl};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == SSWC_BITS_PER_BYTE) begin
              bit_cnt <= SSWC_BIT_CNT_RESET;
              if (state == SSWC_ADDR) begin
                // Foreign address: stay off the line until stop or a new start
                state    <= addr_match ? SSWC_ADDR_ACK : SSWC_SKIP;
                sda_oe_n <= ~addr_match;
              end else if (state == SSWC_CMD) begin
                cmd_index <= shift;
                state     <= SSWC_CMD_ACK;
                sda_oe_n  <= 1'b0;
              end else begin
                write_strobe <= 1'b1;
                write_index  <= cmd_index;
                write_data   <= shift;
                state        <= SSWC_DATA_ACK;
                sda_oe_n     <= 1'b0;
              end
            end
          end
          SSWC_ADDR_ACK: begin
            // Release after the acknowledge clock falls
            if (scl_fall) begin
              sda_oe_n <= 1'b1;
              state    <= SSWC_CMD;
            end
          end
          SSWC_CMD_ACK: begin
            if (scl_fall) begin
              sda_oe_n <= 1'b1;
              state    <= SSWC_DATA;
            end
          end
          SSWC_DATA_ACK: begin
            // no error code byte
            // Anything past the data byte is not acked, as no check exists
            if (scl_fall) begin
              sda_oe_n <= 1'b1;
              state    <= SSWC_SKIP;
            end
          end
          SSWC_SKIP: begin
            sda_oe_n <= 1'b1;
          end
          SSWC_IDLE: begin
            sda_oe_n <= 1'b1;
          end
          default: begin
            state    <= SSWC_IDLE;
            sda_oe_n <= 1'b1;
          end
        endcase
      end
    end
  end

  // Message bytes; a write racing a processor read is not guarded
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      slave_message_byte0 <= SSWC_BYTE_RESET;
      slave_message_byte1 <= SSWC_BYTE_RESET;
    end else if (write_strobe) begin
      if (write_index == SSWC_IDX_MSG_BYTE0) begin
        slave_message_byte0 <= write_data;
      end
      if (write_index == SSWC_IDX_MSG_BYTE1) begin
        slave_message_byte1 <= write_data;
      end
    end
  end

  // One-cycle action pulses decoded from the command register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wake_request            <= 1'b0;
      powerdown_request       <= 1'b0;
      hard_reset_request      <= 1'b0;
      reset_control           <= SSWC_RST_NONE;
      watchdog_reload_command <= 1'b0;
    end else begin
      wake_request            <= 1'b0;
      powerdown_request       <= 1'b0;
      hard_reset_request      <= 1'b0;
      reset_control           <= SSWC_RST_NONE;
      watchdog_reload_command <= 1'b0;
      if (cmd_exec) begin
        case (write_data)
          SSWC_CMD_WAKE_SMI: begin
            wake_request <= ~in_working(sleep_state);
          end
          SSWC_CMD_POWERDOWN: begin
            powerdown_request <= 1'b1;
          end
          SSWC_CMD_RESET_WARM: begin
            if (in_working(sleep_state)) begin
              hard_reset_request <= 1'b1;
              reset_control      <= SSWC_RST_NO_CYCLE;
            end
          end
          SSWC_CMD_RESET_COLD: begin
            if (in_working(sleep_state) || mgmt_powered ||
                graceful_sleep_entry) begin
              hard_reset_request <= 1'b1;
              reset_control      <= SSWC_RST_CYCLE;
            end
          end
          SSWC_CMD_WATCHDOG_RELOAD_COMMAND: begin
            watchdog_reload_command <= 1'b1;
          end
          default: begin
            // Reserved or handled by the flag processes below
          end
        endcase
      end
    end
  end

  // Bus wake status: set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bus_wake_status <= 1'b0;
    end else if (cmd_exec && write_data == SSWC_CMD_WAKE_SMI) begin
      bus_wake_status <= 1'b1;
    end else if (bus_wake_status_clear) begin
      bus_wake_status <= 1'b0;
    end
  end

  // Power button override status, set wins over clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      power_button_override_status <= 1'b0;
    end else if (cmd_exec && write_data == SSWC_CMD_POWERDOWN) begin
      power_button_override_status <= 1'b1;
    end else if (power_button_override_status_clear) begin
      power_button_override_status <= 1'b0;
    end
  end

  // Message reporting stays off until the resume well is reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      message_reporting_disabled <= 1'b0;
    end else if (!rsm_lvl) begin
      message_reporting_disabled <= 1'b0;
    end else if (cmd_exec && write_data == SSWC_CMD_MSG_DISABLE) begin
      message_reporting_disabled <= 1'b1;
    end
  end

  // Link slave status: set only in S0, set wins over clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      link_slave_interrupt_status <= 1'b0;
    end else if (cmd_exec && write_data == SSWC_CMD_LINK_SMI &&
                 in_working(sleep_state)) begin
      link_slave_interrupt_status <= 1'b1;
    end else if (link_slave_interrupt_status_clear) begin
      link_slave_interrupt_status <= 1'b0;
    end
  end

  // Pending link SMI; the state may leave S0 right after the flag sets
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      link_smi_pending <= 1'b0;
    end else if (cmd_exec && write_data == SSWC_CMD_LINK_SMI &&
                 in_working(sleep_state)) begin
      link_smi_pending <= 1'b1;
    end else if (in_working(sleep_state)) begin
      link_smi_pending <= 1'b0;
    end
  end

  // SMI pulse, active low for one cycle, and status bit 16
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      system_mgmt_interrupt_n <= 1'b1;
      smi_status_bit16        <= 1'b0;
    end else begin
      system_mgmt_interrupt_n <= 1'b1;
      if ((cmd_exec && write_data == SSWC_CMD_WAKE_SMI &&
           in_working(sleep_state)) ||
          (link_smi_pending && in_working(sleep_state))) begin
        system_mgmt_interrupt_n <= 1'b0;
        smi_status_bit16 <= 1'b1;
      end else if (smi_status_bit16_clear) begin
        smi_status_bit16 <= 1'b0;
      end
    end
  end

  // Checks on the decoded actions
  chk_wake_asleep: assert property (@(posedge clk) disable iff (!resetn)
    cmd_exec && write_data == SSWC_CMD_WAKE_SMI && !in_working(sleep_state)
    |=> wake_request && system_mgmt_interrupt_n)
    else $error("wake command in sleep did not wake");

  chk_smi_awake: assert property (@(posedge clk) disable iff (!resetn)
    cmd_exec && write_data == SSWC_CMD_WAKE_SMI && in_working(sleep_state)
    |=> !system_mgmt_interrupt_n && !wake_request ##1 smi_status_bit16)
    else $error("wake command in S0 did not raise SMI");

  chk_wake_status: assert property (@(posedge clk) disable iff (!resetn)
    cmd_exec && write_data == SSWC_CMD_WAKE_SMI |=> bus_wake_status)
    else $error("bus wake status not set");

  chk_powerdown: assert property (@(posedge clk) disable iff (!resetn)
    cmd_exec && write_data == SSWC_CMD_POWERDOWN
    |=> powerdown_request && power_button_override_status ##1
        !powerdown_request)
    else $error("powerdown not a single pulse with status");

  chk_warm_reset: assert property (@(posedge clk) disable iff (!resetn)
    cmd_exec && write_data == SSWC_CMD_RESET_WARM
    |=> hard_reset_request == in_working($past(sleep_state)) &&
        (!hard_reset_request || reset_control == SSWC_RST_NO_CYCLE))
    else $error("warm reset gating wrong");

  chk_cold_reset: assert property (@(posedge clk) disable iff (!resetn)
    cmd_exec && write_data == SSWC_CMD_RESET_COLD && !mgmt_powered &&
    !graceful_sleep_entry && !in_working(sleep_state) |=> !hard_reset_request)
    else $error("cold reset honoured after ungraceful sleep");

  chk_cold_bits: assert property (@(posedge clk) disable iff (!resetn)
    hard_reset_request |-> reset_control == SSWC_RST_CYCLE ||
    reset_control == SSWC_RST_NO_CYCLE)
    else $error("reset control bits malformed");

  chk_msg_disable: assert property (@(posedge clk) disable iff (!resetn)
    cmd_exec && write_data == SSWC_CMD_MSG_DISABLE && rsm_lvl
    |=> message_reporting_disabled)
    else $error("message reporting not disabled");

  chk_watchdog_reload_command: assert property (@(posedge clk) disable iff (!resetn)
    watchdog_reload_command |-> $past(cmd_exec) &&
    $past(write_data) == SSWC_CMD_WATCHDOG_RELOAD_COMMAND)
    else $error("watchdog reload without command");

  chk_link_sleep: assert property (@(posedge clk) disable iff (!resetn)
    cmd_exec && write_data == SSWC_CMD_LINK_SMI &&
    !in_working(sleep_state) && !link_slave_interrupt_status
    |=> !link_slave_interrupt_status)
    else $error("link status set during sleep");

  chk_msg_store: assert property (@(posedge clk) disable iff (!resetn)
    write_strobe && write_index == SSWC_IDX_MSG_BYTE0
    |=> slave_message_byte0 == $past(write_data))
    else $error("message byte 0 not overwritten");

  chk_reserved: assert property (@(posedge clk) disable iff (!resetn)
    write_strobe && write_index != SSWC_IDX_COMMAND &&
    write_index != SSWC_IDX_MSG_BYTE0 && write_index != SSWC_IDX_MSG_BYTE1
    |=> $stable(slave_message_byte0) && $stable(slave_message_byte1) &&
        !wake_request && !hard_reset_request)
    else $error("reserved index changed state");

endmodule // sswc_slave

`default_nettype wire

/* File: rtl/sswc_pkg.sv */
// Constants and types shared by the slave write command decoder
`default_nettype none

package sswc_pkg;

  // Receive address after reset, 7 bits; the write address byte is 88h
  localparam logic [6:0] SSWC_RCV_ADDR_RESET = 7'h44;

  // Slave write register indices selected by the command byte
  localparam logic [7:0] SSWC_IDX_COMMAND  = 8'h00;
  localparam logic [7:0] SSWC_IDX_MSG_BYTE0 = 8'h04;
  localparam logic [7:0] SSWC_IDX_MSG_BYTE1 = 8'h05;

  // Command types written into the command register
  localparam logic [7:0] SSWC_CMD_WAKE_SMI    = 8'h01;
  localparam logic [7:0] SSWC_CMD_POWERDOWN   = 8'h02;
  localparam logic [7:0] SSWC_CMD_RESET_WARM  = 8'h03;
  localparam logic [7:0] SSWC_CMD_RESET_COLD  = 8'h04;
  localparam logic [7:0] SSWC_CMD_MSG_DISABLE = 8'h05;
  localparam logic [7:0] SSWC_CMD_WATCHDOG_RELOAD_COMMAND   = 8'h06;
  localparam logic [7:0] SSWC_CMD_LINK_SMI    = 8'h08;

  // System power state encoding on the sleep_state input
  localparam logic [2:0] SSWC_STATE_S0 = 3'h0;
  localparam logic [2:0] SSWC_STATE_S3 = 3'h3;
  localparam logic [2:0] SSWC_STATE_S4 = 3'h4;
  localparam logic [2:0] SSWC_STATE_S5 = 3'h5;

  // Reset control bits 3:1 driven with a hard reset request
  localparam logic [2:0] SSWC_RST_NO_CYCLE = 3'h3;
  localparam logic [2:0] SSWC_RST_CYCLE    = 3'h7;
  localparam logic [2:0] SSWC_RST_NONE     = 3'h0;

  // Bits in one byte on the wire, and reset values
  localparam logic [3:0] SSWC_BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] SSWC_BIT_CNT_RESET = 4'h0;
  localparam logic [7:0] SSWC_BYTE_RESET    = 8'h00;

  // Bus engine states, Gray coded along idle-addr-ack-cmd-ack-data-ack
  typedef enum logic [2:0] {
    SSWC_IDLE      = 3'b000,
    SSWC_ADDR      = 3'b001,
    SSWC_ADDR_ACK  = 3'b011,
    SSWC_CMD       = 3'b010,
    SSWC_CMD_ACK   = 3'b110,
    SSWC_DATA      = 3'b111,
    SSWC_DATA_ACK  = 3'b101,
    SSWC_SKIP      = 3'b100
  } sswc_state_t;

endpackage : sswc_pkg

`default_nettype wire

/* File: rtl/sswc_sync.sv */
// Two-flop synchroniser with registered edge detection
`default_nettype none

module sswc_sync #(
  parameter bit RESET_VAL = 1'b1      // Idle level of the line
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic async_in,
  output var  logic level,
  output var  logic rise,
  output var  logic fall
);

  logic meta;                         // First stage, read by level only
  logic prev;                         // Last level, for edges

  // Capture chain; edges compare stage two with stage three
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta  <= RESET_VAL;
      level <= RESET_VAL;
      prev  <= RESET_VAL;
    end else begin
      meta  <= async_in;
      level <= meta;
      prev  <= level;
    end
  end

  // Edge pulses come from flip-flops as well, one cycle late
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      rise <= level & ~prev;
      fall <= ~level & prev;
    end
  end

endmodule // sswc_sync

`default_nettype wire

/* File: verification/sswc_master_model.sv */
// Bus master model that sends slave byte writes on scl and sda
`default_nettype none

module sswc_master_model (
  input  wire logic sda_line,  // Resolved data wire level
  output var  logic scl,       // Bus clock, stands high between frames
  output var  logic sda_drv    // Data drive, 1 releases to the pull-up
);
  timeunit 1ns;
  timeprecision 100ps;

  // Both lines idle high
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // Data changes mid-low so it never moves while scl is high
  task automatic send_bit(input logic b);
    sda_drv = b;
    #40;
    scl = 1'b1;
    #80;
    scl = 1'b0;
    #40;
  endtask

  // Ninth clock: release data, sample the answer mid-high
  task automatic get_ack(output logic ack);
    sda_drv = 1'b1;
    #40;
    scl = 1'b1;
    #40;
    ack = ~sda_line;
    #40;
    scl = 1'b0;
    #40;
  endtask

  // Eight bits, MSB first, then the answer
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      send_bit(b[i]);
    end
    get_ack(ack);
  endtask

  // one whole write per call; the bench reads between calls
  task automatic write(input logic [7:0] abyte, input logic [7:0] idx,
                       input logic [7:0] data, output logic [2:0] acks);
    acks = 3'h0;
    sda_drv = 1'b0;
    #80;
    scl = 1'b0;
    #40;
    send_byte(abyte, acks[2]);
    // A refused address ends the frame early
    if (acks[2]) begin
      send_byte(idx, acks[1]);
      send_byte(data, acks[0]);
    end
    sda_drv = 1'b0;
    #40;
    scl = 1'b1;
    #40;
    sda_drv = 1'b1;
    #80;
  endtask
endmodule // sswc_master_model

`default_nettype wire

/* File: verification/sswc_slave_tb_top.sv */
// Self-checking bench for the slave write command decoder
`default_nettype none

module sswc_slave_tb_top import sswc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  logic       scl, sda_drv, sda_line, sda_out, sda_oe_n;
  logic [6:0] receive_slave_address = SSWC_RCV_ADDR_RESET;
  logic [2:0] sleep_state = 3'h0;
  logic       mgmt_powered = 1'b0;
  logic       graceful_sleep_entry = 1'b0;
  logic       resume_well_reset_n = 1'b1;
  logic       clr = 1'b0;            // Drives all four status clears
  logic [7:0] b0, b1, ev, exp_b0, exp_b1;
  logic       wake, smi_n, bws, pbo, pd, hr, mrd, wd, lnk, s16;
  logic [2:0] rc;
  logic [7:0] notes [$];             // Expected action vectors, oldest first
  int         errors = 0;
  int         total_checks = 0;
  // Per row: state, mgmt/graceful flags, index, data, action vector
  const logic [31:0] rows [22] = '{
    32'h0000_0101, 32'h3000_0180, 32'h0000_0240, 32'h0000_032c,
    32'h5000_0300, 32'h4000_0400, 32'h4800_043c, 32'h5400_043c,
    32'h0000_043c, 32'h0000_0500, 32'h0000_0602, 32'h0000_0700,
    32'h0000_0000, 32'h0000_0801, 32'h3000_0800, 32'h4000_ff00,
    32'h0004_0000, 32'h0005_0000, 32'h0002_5500, 32'h0009_aa00,
    32'h00ff_0100, 32'h0004_0000};

  always #5 clk = ~clk;

  // Open-drain wire: low when either party pulls it
  assign sda_line = sda_drv & (sda_oe_n | sda_out);

  sswc_master_model sswc_master_model_inst (
    .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));

  sswc_slave sswc_slave_inst (
    .clk(clk), .resetn(resetn), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .receive_slave_address(receive_slave_address),
    .sleep_state(sleep_state), .mgmt_powered(mgmt_powered),
    .graceful_sleep_entry(graceful_sleep_entry),
    .resume_well_reset_n(resume_well_reset_n),
    .bus_wake_status_clear(clr), .power_button_override_status_clear(clr),
    .link_slave_interrupt_status_clear(clr), .smi_status_bit16_clear(clr),
    .slave_message_byte0(b0), .slave_message_byte1(b1),
    .wake_request(wake), .system_mgmt_interrupt_n(smi_n),
    .bus_wake_status(bws), .power_button_override_status(pbo),
    .powerdown_request(pd), .hard_reset_request(hr), .reset_control(rc),
    .message_reporting_disabled(mrd), .watchdog_reload_command(wd),
    .link_slave_interrupt_status(lnk), .smi_status_bit16(s16));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("Checks %0d, errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // One write, then status checks and a clear of every sticky flag
  task automatic run_row(input logic [31:0] r, input logic [7:0] abyte,
                         input logic [2:0] exp_ack);
    logic [7:0] d;
    logic [2:0] acks;
    logic       hit;
    logic       s0;
    d = (r[23:17] == 7'h02) ? 8'($urandom) : r[15:8];
    hit = exp_ack[0] && r[23:16] == SSWC_IDX_COMMAND;
    s0 = r[30:28] == SSWC_STATE_S0;
    @(posedge clk);
    #1;
    sleep_state = r[30:28];
    mgmt_powered = r[27];
    graceful_sleep_entry = r[26];
    if (r[7:0] != 8'h00) notes.push_back(r[7:0]);
    sswc_master_model_inst.write(abyte, r[23:16], d, acks);
    repeat (4) @(posedge clk);
    #1;
    if (exp_ack[0] && r[23:16] == SSWC_IDX_MSG_BYTE0) exp_b0 = d;
    if (exp_ack[0] && r[23:16] == SSWC_IDX_MSG_BYTE1) exp_b1 = d;
    check({5'h0, acks}, {5'h0, exp_ack});
    check(b0, exp_b0);
    check(b1, exp_b1);
    check({7'h0, bws}, {7'h0, hit && d == 8'h01});
    check({7'h0, pbo}, {7'h0, hit && d == 8'h02});
    check({7'h0, lnk}, {7'h0, hit && d == 8'h08 && s0});
    check({7'h0, s16}, {7'h0, hit && (d == 8'h01 || d == 8'h08) && s0});
    check({7'h0, mrd}, {7'h0, hit && d == 8'h05});
    clr = 1'b1;
    resume_well_reset_n = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    clr = 1'b0;
    resume_well_reset_n = 1'b1;
    repeat (3) @(posedge clk);
    check({3'h0, bws, pbo, lnk, s16, mrd}, 8'h00);
  endtask

  // Every action cycle is compared with the oldest note, or with zero when no note is left
  always @(posedge clk) begin
    ev = {wake, pd, hr, rc, wd, ~smi_n};
    if (resetn && ev !== 8'h00) begin
      if (notes.size() == 0) check(ev, 8'h00);
      else check(ev, notes.pop_front());
    end
  end

  initial begin
    exp_b0 = SSWC_BYTE_RESET;
    exp_b1 = SSWC_BYTE_RESET;
    void'($urandom(65));
    repeat (8) @(posedge clk);
    #1;
    resetn = 1'b1;
    repeat (6) @(posedge clk);
    foreach (rows[i]) run_row(rows[i], 8'h88, 3'h7);
    // leave S0 as the link flag sets; the SMI waits for S0
    fork
      run_row(32'h0000_0801, 8'h88, 3'h7);
      begin
        @(posedge lnk);
        #1;
        sleep_state = SSWC_STATE_S3;
        repeat (10) @(posedge clk);
        #1;
        check({7'h0, s16}, 8'h00);
        sleep_state = SSWC_STATE_S0;
      end
    join
    // other and read addresses get no answer
    run_row(32'h0000_0600, 8'h8a, 3'h0);
    run_row(32'h0000_0600, 8'h89, 3'h0);
    @(posedge clk);
    #1;
    receive_slave_address = 7'($urandom);
    run_row(32'h0000_0602, {receive_slave_address, 1'b0}, 3'h7);
    check(8'(notes.size()), 8'h00);
    stop_test();
  end

  // Hang guard, about two and a half times the expected run length of 26 frames
  initial begin
    #300000;
    errors++;
    stop_test();
  end
endmodule // sswc_slave_tb_top

`default_nettype wire
